// ==== hw/clf_config_fault.sv ====
`timescale 1ns/1ps
module clf_config_fault
   import clf_pkg::*;
#(
   parameter int NUM_CH = CLF_NUM_CH
) (
   // Clock and reset
   input  wire logic                    sys_clk,
   input  wire logic                    reset,
   // APB slave
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [11:0]             paddr,
   input  wire logic [31:0]             pwdata,
   output logic                         pready,
   output logic [31:0]                  prdata,
   output logic                         pslverr,
   // Configuration bus
   input  wire clf_cfg_bus_type         cfg_bus,
   // Receive monitors and selects
   input  wire clf_rx_mon_type [3:0]    rx_mon,
   input  wire logic [3:0]              use_local_clock_sel,
   input  wire logic [3:0]              level_density_check_en,
   input  wire logic [3:0][1:0]         rate_sel_level,
   // Status outputs
   output logic [3:0]                   link_fault_n,
   output logic [3:0][1:0]              reframe_mode_sel,
   output logic [3:0]                   framing_char_sel,
   output logic [3:0][1:0]              rate_band_q,
   output logic                         irq
);

   // Tri-level decode, undefined code treated as high
   function automatic clf_level_type decode_level(input logic [1:0] raw);
      clf_level_type lvl;
      lvl = CLF_SEL_HIGH;
      if (raw == 2'b00) begin
         lvl = CLF_SEL_LOW;
      end else if (raw == 2'b01) begin
         lvl = CLF_SEL_MID;
      end
      return lvl;
   endfunction

   logic [7:0]  latch_q [CLF_NUM_LATCH];
   logic        strobe_n_q;
   logic [3:0]  status_q;
   logic [3:0]  mask_q;
   logic [3:0]  fault_d;
   logic [3:0]  fault_q;
   logic [3:0]  dens_low;
   logic [3:0][5:0] cause_d;
   logic [3:0][4:0] ref_cnt_q;
   logic [3:0]  ref_lost_q;
   logic        apb_wr;

   // Write lands only at the edge that completes the transfer
   assign apb_wr = psel && penable && pwrite && pready;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         strobe_n_q <= 1'b1;
      end else begin
         strobe_n_q <= cfg_bus.strobe_n;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         for (int i = 0; i < CLF_NUM_LATCH; i++) begin
            latch_q[i] <= CLF_RST_LATCH;
         end
      end else if (cfg_bus.strobe_n && !strobe_n_q) begin
         latch_q[cfg_bus.addr] <= cfg_bus.data;
      end
   end

   genvar ch;
   generate
      for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
         clf_density_check #(
            .WINDOW_BITS (CLF_DENS_BITS)
         ) u_dens (
            .sys_clk       (sys_clk),
            .reset         (reset),
            .bit_valid     (rx_mon[ch].rx_bit_valid),
            .bit_value     (rx_mon[ch].rx_bit),
            .low_density_q (dens_low[ch])
         );

         always_ff @(posedge sys_clk) begin
            if (reset) begin
               ref_cnt_q[ch]  <= 5'h00;
               ref_lost_q[ch] <= 1'b0;
            end else if (rx_mon[ch].ref_tick) begin
               ref_cnt_q[ch]  <= 5'h00;
               ref_lost_q[ch] <= 1'b0;
            end else if (ref_cnt_q[ch] < 5'(CLF_REF_TMO)) begin
               ref_cnt_q[ch] <= ref_cnt_q[ch] + 5'h01;
            end else begin
               ref_lost_q[ch] <= 1'b1;
            end
         end

         always_comb begin
            cause_d[ch][CLF_C_RATE] = !rx_mon[ch].rate_ok;
            cause_d[ch][CLF_C_AMPL] = level_density_check_en[ch]
                                      && !rx_mon[ch].ampl_ok;
            cause_d[ch][CLF_C_DENS] = level_density_check_en[ch]
                                      && dens_low[ch];
            cause_d[ch][CLF_C_RXPD] = latch_q[ch][CLF_FLD_RXPD];
            cause_d[ch][CLF_C_ULC]  = !use_local_clock_sel[ch];
            cause_d[ch][CLF_C_REF]  = ref_lost_q[ch];
            fault_d[ch] = |cause_d[ch];
         end

         always_ff @(posedge sys_clk) begin
            if (reset) begin
               reframe_mode_sel[ch] <= 2'b00;
               framing_char_sel[ch] <= 1'b0;
               rate_band_q[ch]      <= CLF_SEL_LOW;
            end else begin
               reframe_mode_sel[ch] <=
                  latch_q[ch][CLF_FLD_RFMODE +: 2];
               framing_char_sel[ch] <= latch_q[ch][CLF_FLD_FRAMCH];
               rate_band_q[ch] <= decode_level(rate_sel_level[ch]);
            end
         end
      end
   endgenerate

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         fault_q      <= 4'hf;
         link_fault_n <= 4'h0;
      end else begin
         fault_q      <= fault_d;
         link_fault_n <= ~fault_d;
      end
   end

   // Sticky status on fault rising edge, set beats clear
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         status_q <= 4'h0;
      end else begin
         status_q <= (fault_d & ~fault_q)
                   | (status_q & ~((apb_wr && paddr == CLF_OFS_STATUS)
                                   ? pwdata[3:0] : 4'h0));
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         mask_q <= CLF_RST_MASK;
      end else if (apb_wr && paddr == CLF_OFS_MASK) begin
         mask_q <= pwdata[3:0];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         irq <= 1'b0;
      end else begin
         irq <= |(status_q & mask_q);
      end
   end

   // APB answer in the access cycle's second edge
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && penable && !pready;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
         if (psel && penable && !pready) begin
            if (paddr == CLF_OFS_STATUS) begin
               prdata <= {28'h0, status_q};
            end else if (paddr == CLF_OFS_MASK) begin
               prdata <= {28'h0, mask_q};
            end else if (paddr == CLF_OFS_FAULT) begin
               prdata <= {28'h0, fault_q};
            end else if (paddr == CLF_OFS_CHCFG) begin
               prdata <= {latch_q[3], latch_q[2], latch_q[1], latch_q[0]};
            end else if (paddr == CLF_OFS_DENS) begin
               prdata <= {28'h0, dens_low};
            end else begin
               pslverr <= 1'b1;
            end
         end
      end
   end

   // Assertions
   // local clock select low forces fault
   AST_ULC_FAULT: assert property (@(posedge sys_clk) disable iff (reset)
      !use_local_clock_sel[0] |=> !link_fault_n[0])
      else $error("local clock select low without fault");

   // fault clears only with no causes
   AST_FAULT_CLEAR: assert property (@(posedge sys_clk) disable iff (reset)
      $rose(link_fault_n[1]) |-> $past(cause_d[1]) == 6'h00)
      else $error("fault released while a cause held");

   AST_RATE: assert property (@(posedge sys_clk) disable iff (reset)
      !rx_mon[2].rate_ok |=> !link_fault_n[2])
      else $error("rate fault not shown");

   AST_AMPL: assert property (@(posedge sys_clk) disable iff (reset)
      level_density_check_en[3] && !rx_mon[3].ampl_ok
      |=> !link_fault_n[3])
      else $error("amplitude fault not shown");

   AST_DENS: assert property (@(posedge sys_clk) disable iff (reset)
      level_density_check_en[1] && dens_low[1]
      |=> !link_fault_n[1])
      else $error("density fault not shown");

   AST_WRITE: assert property (@(posedge sys_clk) disable iff (reset)
      cfg_bus.strobe_n && !strobe_n_q
      |=> latch_q[$past(cfg_bus.addr)] == $past(cfg_bus.data))
      else $error("latch did not capture data");

   AST_HOLD: assert property (@(posedge sys_clk) disable iff (reset)
      !(cfg_bus.strobe_n && !strobe_n_q) |=> $stable(latch_q[0]))
      else $error("latch changed without strobe edge");

   AST_RESET: assert property (@(posedge sys_clk)
      reset |=> latch_q[5] == CLF_RST_LATCH)
      else $error("latch not reset");

   AST_RFMODE: assert property (@(posedge sys_clk) disable iff (reset)
      ##1 reframe_mode_sel[1] == $past(latch_q[1][1:0]))
      else $error("reframe mode mismatch");

   AST_LEVEL: assert property (@(posedge sys_clk) disable iff (reset)
      rate_sel_level[0] == 2'b01 |=> rate_band_q[0] == CLF_SEL_MID)
      else $error("mid level not decoded");

   COV_WRITE: cover property (@(posedge sys_clk)
      cfg_bus.strobe_n && !strobe_n_q);
   COV_FAULT: cover property (@(posedge sys_clk) $fell(link_fault_n[0]));
   COV_IRQ:   cover property (@(posedge sys_clk) $rose(irq));

endmodule // clf_config_fault

// ==== shared/clf_pkg.sv ====
package clf_pkg;

   // Channel count and bus widths
   localparam int CLF_NUM_CH     = 4;
   localparam int CLF_ADDR_W     = 4;
   localparam int CLF_DATA_W     = 8;
   localparam int CLF_NUM_LATCH  = 16;

   // APB register byte offsets
   localparam logic [11:0] CLF_OFS_STATUS  = 12'h000;
   localparam logic [11:0] CLF_OFS_MASK    = 12'h004;
   localparam logic [11:0] CLF_OFS_FAULT   = 12'h008;
   localparam logic [11:0] CLF_OFS_CHCFG   = 12'h00c;
   localparam logic [11:0] CLF_OFS_DENS    = 12'h010;

   // Reset values
   localparam logic [3:0]  CLF_RST_MASK    = 4'h0;
   localparam logic [7:0]  CLF_RST_LATCH   = 8'h00;

   // Per-channel latch layout: latch index = channel
   localparam int CLF_FLD_RFMODE  = 0;
   localparam int CLF_FLD_FRAMCH  = 2;
   localparam int CLF_FLD_RXPD    = 3;

   // Transition density window in received bits
   localparam int CLF_DENS_BITS   = 60;

   // Reference clock loss timeout in sys_clk cycles
   localparam int CLF_REF_TMO     = 16;

   // Fault cause field positions in the cause vector
   localparam int CLF_C_RATE = 0;
   localparam int CLF_C_AMPL = 1;
   localparam int CLF_C_DENS = 2;
   localparam int CLF_C_RXPD = 3;
   localparam int CLF_C_ULC  = 4;
   localparam int CLF_C_REF  = 5;

   typedef enum logic [1:0] {
      CLF_SEL_LOW  = 2'b00,
      CLF_SEL_MID  = 2'b01,
      CLF_SEL_HIGH = 2'b10
   } clf_level_type;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] data;
      logic       strobe_n;
   } clf_cfg_bus_type;

   typedef struct packed {
      logic rate_ok;
      logic ampl_ok;
      logic rx_bit_valid;
      logic rx_bit;
      logic ref_tick;
   } clf_rx_mon_type;

endpackage

// ==== hw/clf_density_check.sv ====
`timescale 1ns/1ps
module clf_density_check
   import clf_pkg::*;
#(
   parameter int WINDOW_BITS = CLF_DENS_BITS
) (
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic reset,
   // Serial bit stream
   input  wire logic bit_valid,
   input  wire logic bit_value,
   // Result
   output logic      low_density_q
);

   logic [6:0] run_q;
   logic       last_q;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         last_q <= 1'b0;
      end else if (bit_valid) begin
         last_q <= bit_value;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         run_q         <= 7'h00;
         low_density_q <= 1'b0;
      end else if (bit_valid) begin
         if (bit_value != last_q) begin
            run_q         <= 7'h00;
            low_density_q <= 1'b0;
         end else if (run_q < 7'(WINDOW_BITS - 1)) begin
            run_q <= run_q + 7'h01;
         end else begin
            low_density_q <= 1'b1;
         end
      end
   end

endmodule // clf_density_check

// ==== testbench/clf_host_model.sv ====
`timescale 1ns/1ps
module clf_host_model
   import clf_pkg::*;
(
   // Clock
   input  wire logic      sys_clk,
   // Configuration bus
   output clf_cfg_bus_type cfg_bus
);

   initial cfg_bus = '{4'h0, 8'h00, 1'b1};

   task automatic put(input logic [3:0] a, input logic [7:0] d);
      cfg_bus.strobe_n <= 1'b0;
      cfg_bus.addr     <= a;
      cfg_bus.data     <= d;
      @(posedge sys_clk);
      cfg_bus.strobe_n <= 1'b1;
      @(posedge sys_clk);
      cfg_bus.addr     <= ~a;
      cfg_bus.data     <= ~d;
      @(posedge sys_clk);
   endtask

endmodule // clf_host_model

// ==== testbench/clf_config_fault_tb_top.sv ====
`timescale 1ns/1ps
module clf_config_fault_tb_top
   import clf_pkg::*;
;
   typedef struct packed {
      logic        rd;
      logic [31:0] d;
      logic        er;
   } clf_note_type;

   logic                 sys_clk = 1'b0;
   logic                 reset   = 1'b1;
   logic                 psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0]          paddr   = 12'h000;
   logic [31:0]          pwdata  = 32'h0;
   logic                 pready, pslverr, irq;
   logic [31:0]          prdata;
   clf_cfg_bus_type      cfg_bus;
   clf_rx_mon_type [3:0] rx_mon = '0;
   logic [3:0]           ulc = 4'hf, rok = 4'hf, aok = 4'hf;
   logic [3:0]           hold = 4'h0, stop = 4'h0, lde = 4'hf;
   logic [3:0][1:0]      rate_sel = '0, rmode, band;
   logic [3:0]           link_fault_n, fchar;
   logic [1:0]           exp_rm [4];
   logic                 exp_fc [4];
   clf_note_type         q [$];
   clf_note_type         n;
   int                   errors = 0, compares = 0, cyc = 0;
   logic [3:0]           a;
   logic [7:0]           d;

   always #50 sys_clk = ~sys_clk;

   clf_host_model host (.sys_clk(sys_clk), .cfg_bus(cfg_bus));

   clf_config_fault uut (
      .sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .cfg_bus(cfg_bus),
      .rx_mon(rx_mon), .use_local_clock_sel(ulc),
      .level_density_check_en(lde), .rate_sel_level(rate_sel),
      .link_fault_n(link_fault_n), .reframe_mode_sel(rmode),
      .framing_char_sel(fchar), .rate_band_q(band), .irq(irq));

   task chk(input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         errors++;
         $display("BAD %0t seen %h expected %h", $time, s, e);
      end
   endtask

   task conclude;
      if (errors == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task w(input int c);
      repeat (c) @(posedge sys_clk);
   endtask

   task apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd,
            input logic [31:0] e, input logic er);
      q.push_back('{~wr, e, er});
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= ad;
      pwdata  <= wd;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask

   task cause(input int ch, input int k, input logic on);
      case (k)
         0: rok[ch] <= ~on;
         1: aok[ch] <= ~on;
         2: ulc[ch] <= ~on;
         default: host.put(ch[3:0], {4'h0, on, 3'h0});
      endcase
   endtask

   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors++;
         conclude;
      end
      for (int i = 0; i < 4; i++)
         rx_mon[i] <= '{rok[i], aok[i], 1'b1,
                        hold[i] ? rx_mon[i].rx_bit : ~rx_mon[i].rx_bit,
                        !stop[i] && cyc[1:0] == 2'h0};
   end

   always @(posedge sys_clk) begin
      if (pready === 1'b1 && q.size() > 0) begin
         n = q.pop_front();
         if (n.rd) chk(prdata, n.d);
         chk(pslverr, n.er);
      end
   end

   initial begin
      void'($urandom(32'he6f6fa14));
      w(16);
      reset <= 1'b0;
      w(30);
      chk(link_fault_n, 4'hf);
      chk({rmode, fchar}, 12'h000);
      apb(1'b0, CLF_OFS_MASK, 32'h0, 32'h0, 1'b0);
      apb(1'b0, 12'h020, 32'h0, 32'h0, 1'b1);
      apb(1'b1, CLF_OFS_STATUS, 32'hf, 32'h0, 1'b0);
      apb(1'b0, CLF_OFS_STATUS, 32'h0, 32'h0, 1'b0);
      rok[2] <= 1'b0;
      w(3);
      rok[2] <= 1'b1;
      w(3);
      apb(1'b0, CLF_OFS_STATUS, 32'h0, 32'h4, 1'b0);
      chk(irq, 1'b0);
      apb(1'b1, CLF_OFS_MASK, 32'h4, 32'h0, 1'b0);
      w(2);
      chk(irq, 1'b1);
      apb(1'b1, CLF_OFS_STATUS, 32'h4, 32'h0, 1'b0);
      w(2);
      chk(irq, 1'b0);
      for (int ch = 0; ch < 4; ch++)
         for (int k = 0; k < 4; k++) begin
            cause(ch, k, 1'b1);
            w(3);
            chk(link_fault_n, 4'(~(4'h1 << ch)));
            cause(ch, k, 1'b0);
            w(3);
            chk(link_fault_n, 4'hf);
         end
      lde[3] <= 1'b0;
      aok[3] <= 1'b0;
      w(3);
      chk(link_fault_n, 4'hf);
      lde[3] <= 1'b1;
      w(3);
      chk(link_fault_n, 4'h7);
      aok[3] <= 1'b1;
      w(3);
      hold[1] <= 1'b1;
      w(50);
      chk(link_fault_n, 4'hf);
      w(20);
      chk(link_fault_n, 4'hd);
      apb(1'b0, CLF_OFS_FAULT, 32'h0, 32'h2, 1'b0);
      apb(1'b0, CLF_OFS_DENS, 32'h0, 32'h2, 1'b0);
      hold[1] <= 1'b0;
      w(4);
      chk(link_fault_n, 4'hf);
      stop[3] <= 1'b1;
      w(12);
      chk(link_fault_n, 4'hf);
      w(10);
      chk(link_fault_n, 4'h7);
      stop[3] <= 1'b0;
      w(8);
      for (int i = 0; i < 4; i++) begin
         exp_rm[i] = 2'h0;
         exp_fc[i] = 1'b0;
      end
      for (int i = 0; i < 10; i++) begin
         a = 4'($urandom % 4);
         d = 8'($urandom) & 8'h07;
         host.put(a, d);
         exp_rm[a] = d[1:0];
         exp_fc[a] = d[2];
         host.put(4'(4 + $urandom % 12), 8'hff);
         w(2);
         for (int c = 0; c < 4; c++) begin
            chk(rmode[c], exp_rm[c]);
            chk(fchar[c], exp_fc[c]);
         end
      end
      apb(1'b0, CLF_OFS_CHCFG, 32'h0,
          {5'h0, exp_fc[3], exp_rm[3], 5'h0, exp_fc[2], exp_rm[2],
           5'h0, exp_fc[1], exp_rm[1], 5'h0, exp_fc[0], exp_rm[0]},
          1'b0);
      for (int c = 0; c < 4; c++) begin
         rate_sel <= {4{c[1:0]}};
         w(3);
         chk(band, {4{c == 3 ? 2'h2 : c[1:0]}});
      end
      reset <= 1'b1;
      w(2);
      reset <= 1'b0;
      w(2);
      chk({rmode, fchar}, 12'h000);
      apb(1'b0, CLF_OFS_MASK, 32'h0, 32'h0, 1'b0);
      conclude;
   end

endmodule // clf_config_fault_tb_top
